// file: rtl/fis_pkg.sv
`default_nettype none

package fis_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 8;    // 125 mhz system clock
	localparam int FILT_PERIOD_MIN_US = 20;   // shortest filter clock period
	localparam int FILT_PERIOD_MAX_US = 3000; // longest filter clock period
	// least time rounds up, longest time rounds down
	localparam int FILT_MIN_CYC =
		(FILT_PERIOD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_MAX_CYC =
		(FILT_PERIOD_MAX_US * 1000) / CLK_PERIOD_NS;

	// ****************************************
	// filter divider
	// ****************************************
	localparam logic [6:0] DIV_RATIO_LOW  = 7'h08; // select low
	localparam logic [6:0] DIV_RATIO_HIGH = 7'h40; // select high

	// ****************************************
	// frame layout
	// ****************************************
	localparam logic [4:0] FRAME_LONG  = 5'h10; // strap low
	localparam logic [4:0] FRAME_SHORT = 5'h08; // strap high
	localparam int BIT_UV   = 7;
	localparam int BIT_OT   = 6;
	localparam int BIT_PAR_ALL = 5; // parity over all inputs
	localparam int BIT_PAR_UP  = 4; // parity over inputs 5 to 8
	localparam int BIT_PAR_LO  = 3; // parity over inputs 1 to 4
	localparam int BIT_PAR_MID = 2; // parity over inputs 3 to 6
	localparam int BIT_LOW  = 1;
	localparam int BIT_STOP = 0;
	localparam logic LOW_LEVEL  = 1'b0;
	localparam logic STOP_LEVEL = 1'b1;

	// ****************************************
	// pin bundle positions and reset levels
	// ****************************************
	localparam int PIN_CS   = 6;
	localparam int PIN_SCK  = 5;
	localparam int PIN_MOSI = 4;
	localparam int PIN_FLS  = 3;
	localparam int PIN_UV   = 2;
	localparam int PIN_OT   = 1;
	localparam int PIN_LOST = 0;
	localparam logic [6:0] PIN_RST = 7'h46; // select, alarms idle high
	localparam int FIFO_DEPTH = 8;

	// take a bit only where the last two sync stages agree
	function automatic logic [31:0] agree(input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] old);
		agree = (a & ~(a ^ b)) | (old & (a ^ b));
	endfunction : agree

endpackage : fis_pkg

`default_nettype wire

// file: rtl/stream_if.sv
`default_nettype none

// valid/ready word stream between the shifter and its buffer
interface stream_if #(parameter int W = 16);
	logic         valid; // word offered
	logic         ready; // word accepted
	logic [W-1:0] data;  // word content
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

// file: rtl/word_fifo.sv
`default_nettype none

// ****************************************
// word buffer with registered head
// ****************************************
module word_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// filling side
	stream_if.snk             wr,
	// draining side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];  // storage
	logic [AW-1:0] wp_q;           // write index
	logic [AW-1:0] rp_q;           // read index
	logic [CW-1:0] cnt_q;          // words held in storage
	logic          push;
	logic          pop;

	// honest full: ready drops the moment storage is full
	assign wr.ready = (cnt_q != CW'(DEPTH));
	assign push     = wr.valid & wr.ready;
	// refill the head whenever it empties or is taken
	assign pop      = (cnt_q != '0) & (~out_valid | out_ready);

	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= wr.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end

	// head register keeps the output straight from flops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem_q[rp_q];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : word_fifo

`default_nettype wire

// file: rtl/input_filter.sv
`default_nettype none

// ****************************************
// two-step sampling filter on divided oscillator
// ****************************************
module input_filter #(
	parameter int N = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// pins
	input  wire logic [N-1:0] comp_in,
	input  wire logic         osc_in,
	input  wire logic         div_sel,
	// results
	output logic [N-1:0]      state_q,
	output logic              tick_q
);
	localparam int PW = N + 2;

	logic [PW-1:0] s1_q, s2_q, s3_q; // three-flop synchroniser
	logic [PW-1:0] lvl_q;            // agreed pin levels
	logic [PW-1:0] lvl_d;
	logic          osc_rise;
	logic [6:0]    ratio;
	logic [6:0]    div_q;            // oscillator edge count
	logic [N-1:0]  st1_q, st2_q;     // sample stages

	assign lvl_d = PW'(fis_pkg::agree(32'(s2_q), 32'(s3_q), 32'(lvl_q)));
	assign osc_rise = lvl_d[N] & ~lvl_q[N];
	assign ratio = lvl_q[N+1] ? fis_pkg::DIV_RATIO_HIGH
		: fis_pkg::DIV_RATIO_LOW;

	// pin synchroniser
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end else begin
			s1_q  <= {div_sel, osc_in, comp_in};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// divider to filter clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (osc_rise) begin
				if (div_q >= ratio - 7'h01) begin
					div_q  <= '0;
					tick_q <= 1'b1;
				end else begin
					div_q <= div_q + 7'h01;
				end
			end
		end
	end

	// two stages, then commit where they agree: 2..3 periods
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st1_q   <= '0;
			st2_q   <= '0;
			state_q <= '0;
		end else if (tick_q) begin
			st1_q   <= lvl_q[N-1:0];
			st2_q   <= st1_q;
			state_q <= N'(fis_pkg::agree(32'(st1_q), 32'(st2_q),
				32'(state_q)));
		end
	end

	a_div_range:
	// checked per counted edge: a ratio switch may leave a high count
	// that the next edge wraps
	assert property (@(posedge clk) disable iff (reset)
		osc_rise |=> div_q < $past(ratio))
	else $error("divider count beyond ratio");

	a_filter_take:
	assert property (@(posedge clk) disable iff (reset)
		tick_q |=> ((state_q ^ $past(st1_q)) & ~$past(st1_q ^ st2_q))
		== '0)
	else $error("agreeing samples not committed");

	a_filter_hold:
	assert property (@(posedge clk) disable iff (reset)
		tick_q |=> ((state_q ^ $past(state_q)) & $past(st1_q ^ st2_q))
		== '0)
	else $error("state moved on disagreeing samples");

endmodule : input_filter

`default_nettype wire

// file: rtl/filtered_input_spi_shifter.sv
`default_nettype none

// ****************************************
// filtered eight-input spi mode 0 shifter
// ****************************************
module filtered_input_spi_shifter #(
	parameter int N               = 8,
	parameter int FILT_MIN_CYCLES = fis_pkg::FILT_MIN_CYC,
	parameter int FILT_MAX_CYCLES = fis_pkg::FILT_MAX_CYC
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// spi pins
	input  wire logic         cs_n,
	input  wire logic         sck,
	input  wire logic         mosi,
	output logic              miso,
	output logic              miso_n,
	output logic              miso_oe,
	// straps
	input  wire logic         frame_length_select,
	input  wire logic         filter_divider_select,
	// analog front end
	input  wire logic [N-1:0] comp_in,
	input  wire logic         osc_in,
	input  wire logic         undervoltage_alarm_n,
	input  wire logic         overtemp_alarm_n,
	input  wire logic         supply_lost,
	// status
	output logic [N-1:0]      input_state,
	output logic              filter_period_fault,
	// received words
	output logic [15:0]       rx_data,
	output logic              rx_valid,
	input  wire logic         rx_ready,
	output logic              rx_overrun
);

	// ****************************************
	// declarations
	// ****************************************
	logic [6:0]  s1_q, s2_q, s3_q; // pin synchroniser stages
	logic [6:0]  lvl_q;            // agreed pin levels
	logic [6:0]  lvl_d;
	logic        cs_fall;          // select went low
	logic        cs_rise;          // select went high
	logic        active;           // select is low
	logic        sck_rise;
	logic        sck_fall;
	logic        mosi_now;
	logic        lost_now;
	logic [15:0] sh_q;             // output shift register
	logic [15:0] sh_d;
	logic [15:0] load_word;        // frame built at select fall
	logic        cap_q;            // data bit caught on rising edge
	logic        seen_q;           // a rising edge came this frame
	logic        short_q;          // frame length latched at fall
	logic [4:0]  cnt_q;            // bits received this frame
	logic [15:0] rx_q;             // received bits
	logic [15:0] pend_q;           // word waiting for the buffer
	logic        pend_v_q;
	logic [19:0] per_q;            // cycles since last filter tick
	logic        tick;
	logic        miso_d;

	stream_if #(.W(16)) rx_if ();

	// ****************************************
	// pin synchroniser, change counts once stages agree
	// ****************************************
	assign lvl_d = 7'(fis_pkg::agree(32'(s2_q), 32'(s3_q), 32'(lvl_q)));

	// three flops per pin
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q  <= fis_pkg::PIN_RST;
			s2_q  <= fis_pkg::PIN_RST;
			s3_q  <= fis_pkg::PIN_RST;
			lvl_q <= fis_pkg::PIN_RST;
		end else begin
			s1_q  <= {cs_n, sck, mosi, frame_length_select,
				undervoltage_alarm_n, overtemp_alarm_n, supply_lost};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	// edges of agreed levels
	assign cs_fall  = lvl_q[fis_pkg::PIN_CS] & ~lvl_d[fis_pkg::PIN_CS];
	assign cs_rise  = ~lvl_q[fis_pkg::PIN_CS] & lvl_d[fis_pkg::PIN_CS];
	assign active   = ~lvl_q[fis_pkg::PIN_CS];
	assign sck_rise = ~lvl_q[fis_pkg::PIN_SCK] & lvl_d[fis_pkg::PIN_SCK];
	assign sck_fall = lvl_q[fis_pkg::PIN_SCK] & ~lvl_d[fis_pkg::PIN_SCK];
	assign mosi_now = lvl_d[fis_pkg::PIN_MOSI];
	assign lost_now = lvl_d[fis_pkg::PIN_LOST];

	// ****************************************
	// input filter
	// ****************************************
	input_filter #(.N(N)) u_filter (
		.clk     (clk),
		.reset   (reset),
		.comp_in (comp_in),
		.osc_in  (osc_in),
		.div_sel (filter_divider_select),
		.state_q (input_state),
		.tick_q  (tick)
	);

	// ****************************************
	// filter period watch
	// ****************************************
	// flags a filter clock faster or slower than the legal span;
	// the oscillator is external, so this only reports
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			per_q               <= '0;
			filter_period_fault <= 1'b0;
		end else if (tick) begin
			per_q <= '0;
			filter_period_fault <= (per_q < 20'(FILT_MIN_CYCLES - 1)) |
				(per_q > 20'(FILT_MAX_CYCLES - 1));
		end else if (per_q <= 20'(FILT_MAX_CYCLES)) begin
			per_q <= per_q + 20'h00001;
		end else begin
			// stalled oscillator: long period reported at once
			filter_period_fault <= 1'b1;
		end
	end

	// ****************************************
	// frame assembly
	// ****************************************
	// parity bits high on even count of ones
	always_comb begin
		load_word = '0;
		load_word[15:8] = input_state; // input eight leads
		if (!lvl_d[fis_pkg::PIN_FLS]) begin
			load_word[fis_pkg::BIT_UV]  =
				lvl_d[fis_pkg::PIN_UV];
			load_word[fis_pkg::BIT_OT]  = lvl_d[fis_pkg::PIN_OT];
			load_word[fis_pkg::BIT_PAR_ALL] = ~^input_state;
			load_word[fis_pkg::BIT_PAR_UP] = ~^input_state[7:4];
			load_word[fis_pkg::BIT_PAR_LO] = ~^input_state[3:0];
			load_word[fis_pkg::BIT_PAR_MID] = ~^input_state[5:2];
			load_word[fis_pkg::BIT_LOW]  = fis_pkg::LOW_LEVEL;
			load_word[fis_pkg::BIT_STOP] = fis_pkg::STOP_LEVEL;
		end
	end

	// ****************************************
	// shift register
	// ****************************************
	// next value of the shifter, msb on the wire unless supply is lost
	always_comb begin
		sh_d = sh_q;
		if (cs_fall) begin
			sh_d = load_word;
		end else if (active && sck_fall && seen_q) begin
			// falling edge before any rising edge is ignored
			sh_d = {sh_q[14:0], cap_q};
		end
	end

	// shifter register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	// rising edge capture, only while selected
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cap_q   <= 1'b0;
			seen_q  <= 1'b0;
			cnt_q   <= '0;
			rx_q    <= '0;
			short_q <= 1'b0;
		end else if (cs_fall) begin
			seen_q  <= 1'b0;
			cnt_q   <= '0;
			short_q <= lvl_d[fis_pkg::PIN_FLS]; // strap held in frame
		end else if (active && sck_rise) begin
			cap_q  <= mosi_now;
			seen_q <= 1'b1;
			rx_q   <= {rx_q[14:0], mosi_now};
			if (cnt_q != 5'h1f) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// ****************************************
	// serial output
	// ****************************************
	// lost supply pulls the wire low so the stop bit reads low
	assign miso_d = lost_now ? 1'b0 : sh_d[15];

	// output pins registered; float when select is high
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			miso    <= 1'b0;
			miso_n  <= 1'b1;
			miso_oe <= 1'b0;
		end else begin
			miso    <= miso_d;
			miso_n  <= ~miso_d;
			miso_oe <= ~lvl_d[fis_pkg::PIN_CS];
		end
	end

	// ****************************************
	// received words into the buffer
	// ****************************************
	// a frame counts once all its bits came within one select
	// cycle; the master cannot be stalled, so a word that finds
	// the holding slot busy is dropped and reported
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pend_q     <= '0;
			pend_v_q   <= 1'b0;
			rx_overrun <= 1'b0;
		end else begin
			rx_overrun <= 1'b0;
			if (pend_v_q && rx_if.ready) begin
				pend_v_q <= 1'b0;
			end
			if (cs_rise && cnt_q >= (short_q ? fis_pkg::FRAME_SHORT
				: fis_pkg::FRAME_LONG)) begin
				if (pend_v_q && !rx_if.ready) begin
					rx_overrun <= 1'b1;
				end else begin
					pend_q   <= short_q ? {8'h00, rx_q[7:0]} : rx_q;
					pend_v_q <= 1'b1;
				end
			end
		end
	end

	assign rx_if.valid = pend_v_q;
	assign rx_if.data  = pend_q;

	word_fifo #(.W(16), .DEPTH(fis_pkg::FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.wr        (rx_if),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// ****************************************
	// checks
	// ****************************************
	a_idle_float:
	assert property (@(posedge clk) disable iff (reset)
		(lvl_d[fis_pkg::PIN_CS] && lvl_q[fis_pkg::PIN_CS]) |=> !miso_oe)
	else $error("output driven while deselected");

	a_load_frame:
	assert property (@(posedge clk) disable iff (reset)
		cs_fall |=> sh_q[15:8] == $past(input_state) && miso_oe)
	else $error("inputs not loaded at select fall");

	a_first_bit:
	assert property (@(posedge clk) disable iff (reset)
		cs_fall |=> miso == ($past(lost_now) ? 1'b0
		: $past(input_state[N-1])))
	else $error("first bit not on wire at select fall");

	a_no_early_shift:
	assert property (@(posedge clk) disable iff (reset)
		(sck_fall && !seen_q && !cs_fall) |=> $stable(sh_q))
	else $error("shift before first rising edge");

	a_shift_msb:
	assert property (@(posedge clk) disable iff (reset)
		(active && sck_fall && seen_q && !cs_fall)
		|=> sh_q == {$past(sh_q[14:0]), $past(cap_q)})
	else $error("shift did not move one place");

	a_sample_rise:
	assert property (@(posedge clk) disable iff (reset)
		(active && sck_rise && !cs_fall) |=> cap_q == $past(mosi_now)
		&& rx_q[0] == $past(mosi_now) && seen_q)
	else $error("data input not sampled on rise");

	a_stop_bits:
	assert property (@(posedge clk) disable iff (reset)
		(cs_fall && !lvl_d[fis_pkg::PIN_FLS])
		|=> sh_q[1:0] == 2'h1 && sh_q[5] == ~^$past(input_state)
		&& sh_q[2] == ~^$past(input_state[5:2]))
	else $error("control bits wrong in long frame");

	a_short_frame:
	assert property (@(posedge clk) disable iff (reset)
		(cs_fall && lvl_d[fis_pkg::PIN_FLS]) |=> sh_q[7:0] == 8'h00)
	else $error("short frame carries control bits");

	a_lost_low:
	assert property (@(posedge clk) disable iff (reset)
		lost_now |=> !miso)
	else $error("output not forced low on lost supply");

endmodule : filtered_input_spi_shifter

`default_nettype wire

// file: testbench/spi_master_model.sv
`default_nettype none

// ****************************************
// spi mode 0 master facing the shifter
// ****************************************
module spi_master_model (
	// clock
	input  wire logic clk,
	// spi pins
	output logic      cs_n,
	output logic      sck,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HALF = 6; // clocks per sck phase, above the four needed

	// idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		mosi = 1'b0;
	end

	// one sck phase, changes land just after an edge
	task automatic half();
		repeat (HALF) @(posedge clk);
		#1;
	endtask : half

	// one select cycle of n bits; oe is low if output floated at any bit sample
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx, output logic oe);
		int i;
		rx = 16'h0000;
		oe = 1'b1;
		@(posedge clk);
		#1;
		cs_n = 1'b0; // sck is low here
		for (i = 0; i < n; i++) begin
			mosi = tx[n-1-i]; // msb first, set while sck low
			half();
			rx = {rx[14:0], miso}; // taken as sck rises
			oe = oe & miso_oe;
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		half();
		cs_n = 1'b1; // sck low again
		mosi = ~mosi; // the line does not keep the last bit
		half();
		half();
	endtask : xfer

	// clock and data wiggle with select high; must be ignored
	task automatic noise();
		repeat (4) begin
			sck = 1'b1;
			mosi = ~mosi;
			half();
			sck = 1'b0;
			half();
		end
	endtask : noise

	// select falls with sck high, then a stray falling edge follows;
	// a normal xfer continues the frame afterwards
	task automatic skewed();
		@(posedge clk);
		#1;
		sck = 1'b1;
		half();
		cs_n = 1'b0; // deliberate select move with sck high
		half();
		sck = 1'b0;
		half();
	endtask : skewed
endmodule : spi_master_model

`default_nettype wire

// file: testbench/filtered_input_spi_shifter_test.sv
`default_nettype none

// ****************************************
// self-checking bench for the filtered shifter
// ****************************************
module filtered_input_spi_shifter_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int P = 64;      // filter tick spacing with divide by 8
	localparam int LIMIT = 60000; // cycle ceiling against hangs
	logic        clk, reset, cs_n, sck, mosi, miso, miso_n, miso_oe;
	logic        fls, fds, osc, osc_run, uv_n, ot_n, lost, fault;
	logic        rx_valid, rx_ready, ovr, oe;
	logic [7:0]  comp, state;
	logic [15:0] rx_data, tx, got;
	logic [31:0] seed, r;
	logic [7:0]  q[$];
	int          failures, n_compared, n_ovr, ovr0, cycles, k, d;

	filtered_input_spi_shifter #(.FILT_MIN_CYCLES(4),
		.FILT_MAX_CYCLES(1000)) uut (.clk(clk), .reset(reset),
		.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso),
		.miso_n(miso_n), .miso_oe(miso_oe), .frame_length_select(fls),
		.filter_divider_select(fds), .comp_in(comp), .osc_in(osc),
		.undervoltage_alarm_n(uv_n), .overtemp_alarm_n(ot_n),
		.supply_lost(lost), .input_state(state),
		.filter_period_fault(fault), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(ovr));

	spi_master_model m (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe));

	// system clock and a slower oscillator of eight clocks, stallable
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		osc = 1'b0;
		forever #32 osc = osc_run & ~osc;
	end

	// hang guard, overrun pulse counter and inverted output watch;
	// sampled mid-cycle so registered outputs have settled
	always @(negedge clk) begin
		cycles++;
		if (ovr === 1'b1)
			n_ovr++;
		if (miso_oe === 1'b1)
			check("miso_n", {15'h0, miso_n}, {15'h0, ~miso});
		if (cycles == LIMIT) begin
			failures++;
			end_sim();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// expected frame from input states and alarms
	function automatic logic [15:0] frame_of(logic [7:0] s, logic uv,
		logic ot, logic short_f);
		if (short_f)
			return {8'h00, s};
		return {s, uv, ot, ~^s, ~^s[7:4], ~^s[3:0], ~^s[5:2], 2'h1};
	endfunction : frame_of

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			failures++;
		end
	endtask : check

	// wait for a received word, compare it, accept it
	task automatic take(input logic [15:0] exp);
		int i;
		for (i = 0; i < 40 && rx_valid !== 1'b1; i++)
			tick(1);
		check("rx_valid", {15'h0000, rx_valid}, 16'h0001);
		check("rx_data", rx_data, exp);
		rx_ready = 1'b1;
		tick(1);
		rx_ready = 1'b0;
	endtask : take

	// new comparator levels; old held, then new taken in the window
	task automatic step(input logic [7:0] v, input int per);
		logic [7:0] old;
		old = state;
		comp = v;
		tick(2 * per - 1);
		check("hold", {8'h00, state}, {8'h00, old});
		tick(per + 8);
		check("commit", {8'h00, state}, {8'h00, v});
	endtask : step

	// one frame read by the master, with output enable watched
	task automatic frame(input int n, input logic [15:0] exp);
		check("oe idle", {15'h0000, miso_oe}, 16'h0000);
		m.xfer(tx, n, got, oe);
		check("miso", got, exp);
		check("oe", {15'h0000, oe}, 16'h0001);
	endtask : frame

	task automatic end_sim();
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 32'h0000_0037;
		{reset, fls, fds, lost, rx_ready} = 5'h10;
		{uv_n, ot_n} = 2'h3;
		osc_run = 1'b1;
		comp = 8'h00;
		tick(2);
		reset = 1'b0;
		tick(6);
		// filter timing, a glitch, the slow divider
		r = xs();
		step(r[7:0], P);
		step(~r[7:0], P);
		comp[0] = ~comp[0];
		tick(20);
		comp[0] = ~comp[0];
		tick(4 * P);
		check("glitch", {8'h00, state}, {8'h00, comp});
		check("fault", {15'h0000, fault}, 16'h0000);
		fds = 1'b1;
		step(~comp, 8 * P);
		fds = 1'b0;
		tick(2 * P);
		// frames of both lengths, random states and alarms
		for (k = 0; k < 8; k++) begin
			fls = k[0]; // strap moves with select high
			r = xs();
			uv_n = r[8];
			ot_n = r[9];
			step(r[7:0], P);
			tx = r[31:16];
			frame(fls ? 8 : 16, frame_of(r[7:0], r[8], r[9], fls));
			take(fls ? {8'h00, tx[7:0]} : tx);
		end
		// activity with select high
		m.noise();
		tick(10);
		check("noise", {15'h0000, rx_valid}, 16'h0000);
		// stray falling edge right after select must not shift
		m.skewed();
		m.xfer(tx, 8, got, oe);
		check("skew", got, {8'h00, comp});
		take({8'h00, tx[7:0]});
		// short frame dropped, next full one kept
		fls = 1'b1;
		m.xfer(16'h00a5, 7, got, oe);
		tick(10);
		check("short", {15'h0000, rx_valid}, 16'h0000);
		tx = 16'h003c;
		frame(8, {8'h00, comp});
		take(16'h003c);
		// lost supply forces the output low
		lost = 1'b1;
		fls = 1'b0;
		tick(6);
		frame(16, 16'h0000);
		lost = 1'b0;
		rx_ready = 1'b1;
		tick(10);
		rx_ready = 1'b0;
		// buffer filled past its depth with the sink stalled
		fls = 1'b1;
		ovr0 = n_ovr;
		for (k = 0; k < 12; k++) begin
			r = xs();
			q.push_back(r[7:0]);
			m.xfer({8'h00, r[7:0]}, 8, got, oe);
		end
		d = 0;
		while (rx_valid === 1'b1 && d < 12) begin
			take({8'h00, q[d]});
			d++;
			tick(2);
		end
		check("words", 16'(d + n_ovr - ovr0), 16'h000c);
		check("dropped", {15'h0000, n_ovr > ovr0}, 16'h0001);
		check("kept", 16'(d), 16'(fis_pkg::FIFO_DEPTH + 2));
		// stalled oscillator reported, then cleared by good periods
		osc_run = 1'b0;
		tick(1200);
		check("stall", {15'h0000, fault}, 16'h0001);
		osc_run = 1'b1;
		tick(3 * P);
		check("fault", {15'h0000, fault}, 16'h0000);
		end_sim();
	end
endmodule : filtered_input_spi_shifter_test

`default_nettype wire
